// ===== logic/dtsr_conv_seq.sv
`timescale 1ns/1ps
`default_nettype none
module dtsr_conv_seq import dtsr_pkg::*; #(
   parameter int unsigned P_PHASE_CYC = PHASE_CYC,
   parameter int unsigned P_RATE_CYC = RATE_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_standby,
   input wire logic i_oneshot,
   input wire logic [10:0] i_local_sample,
   input wire logic [10:0] i_remote_sample,
   input wire logic i_remote_fault,
   output logic o_busy,
   output logic o_adc_active,
   output logic o_adc_remote,
   output logic [7:0] o_local_whole,
   output logic [7:0] o_local_frac,
   output logic [7:0] o_remote_whole,
   output logic [7:0] o_remote_frac
);
   dtsr_conv_e state;
   logic [CNT_W-1:0] phase_cnt;
   logic [CNT_W-1:0] rate_cnt;
   logic [10:0] local_hold;
   logic standby_q;
   logic oneshot_run;
   logic standby_rise;
   logic auto_due;
   logic phase_end;
   logic start;

   assign standby_rise = i_standby & ~standby_q;
   assign phase_end = (phase_cnt == CNT_W'(P_PHASE_CYC - 1));
   assign auto_due = !i_standby && (rate_cnt >= CNT_W'(P_RATE_CYC - 1));
   // one-shot ignored while a conversion runs
   assign start = (state == CONV_IDLE) && (i_oneshot || auto_due);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         standby_q <= 1'b0;
      end else begin
         standby_q <= i_standby;
      end
   end

   // rate timer: held at zero in standby, restarted by every start
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rate_cnt <= '0;
      end else if (i_standby || start || state != CONV_IDLE) begin
         rate_cnt <= '0;
      end else begin
         rate_cnt <= rate_cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= CONV_IDLE;
         phase_cnt <= '0;
         oneshot_run <= 1'b0;
         local_hold <= '0;
      end else begin
         case (state)
            CONV_IDLE: begin
               phase_cnt <= '0;
               if (start) begin
                  state <= CONV_LOCAL;
                  oneshot_run <= i_oneshot;
               end
            end
            CONV_LOCAL: begin
               if (standby_rise && !oneshot_run) begin
                  state <= CONV_IDLE;
               end else if (phase_end) begin
                  local_hold <= i_local_sample;
                  phase_cnt <= '0;
                  state <= CONV_REMOTE;
               end else begin
                  phase_cnt <= phase_cnt + CNT_W'(1);
               end
            end
            CONV_REMOTE: begin
               if ((standby_rise && !oneshot_run) || phase_end) begin
                  state <= CONV_IDLE;
               end else begin
                  phase_cnt <= phase_cnt + CNT_W'(1);
               end
            end
            default: begin
               state <= CONV_IDLE;
            end
         endcase
      end
   end

   // both channels committed together, whole and fraction in one cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_local_whole <= '0;
         o_local_frac <= '0;
         o_remote_whole <= '0;
         o_remote_frac <= '0;
      end else if (state == CONV_REMOTE && phase_end && !(standby_rise && !oneshot_run)) begin
         o_local_whole <= local_hold[10:3];
         o_local_frac <= {local_hold[2:0], 5'b0_0000};
         o_remote_whole <= i_remote_fault ? FAULT_WHOLE : i_remote_sample[10:3];
         o_remote_frac <= {i_remote_sample[2:0], 5'b0_0000};
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_busy <= 1'b0;
         o_adc_active <= 1'b0;
         o_adc_remote <= 1'b0;
      end else begin
         o_busy <= start || (state != CONV_IDLE && !(phase_end && state == CONV_REMOTE)
                   && !(standby_rise && !oneshot_run));
         o_adc_active <= start || (state == CONV_LOCAL && !(standby_rise && !oneshot_run))
                   || (state == CONV_REMOTE && !phase_end && !(standby_rise && !oneshot_run));
         // an abandoned sequence drops the remote phase with the active flag
         o_adc_remote <= !(standby_rise && !oneshot_run)
                   && ((state == CONV_LOCAL && phase_end) || (state == CONV_REMOTE && !phase_end));
      end
   end
endmodule : dtsr_conv_seq
`default_nettype wire

// ===== logic/dtsr_top.sv
// Summary of operation
// - each sequence measures local then remote; both results appear together.
// - with standby clear, conversions repeat automatically, paced by the rate timer.
// - status busy bit is set during a conversion, clear otherwise.
// - reads during conversion return the last completed results.
// - config bit 6 set to one enters standby, stopping converter and timer.
// - in standby registers are kept and the slave port keeps answering.
// - one-shot command starts a sequence in either mode.
// - standby during an automatic conversion abandons it without updating temperature registers.
// - a full sequence takes about 125 ms.
// - slave supports write-byte, read-byte, send-byte and receive-byte only.
// - receive-byte returns the register selected by the stored pointer.
// - index 00h gives local, 01h remote whole temperature, 1 C per LSB.
// - data bytes go out most significant bit first.
// - 10h holds remote, 11h local extra bits, 0.125 C resolution.
// - extended registers hold the fraction in bits 7 to 5.
// - main and extended registers of a channel update in one cycle.
// - remote diode fault loads remote main register with all ones.
// - one-shot during conversion is ignored; in free run it restarts the timer.
// - clock held low beyond the bus timeout resets the serial protocol.
`timescale 1ns/1ps
`default_nettype none
module dtsr_top import dtsr_pkg::*; #(
   parameter int unsigned P_PHASE_CYC = PHASE_CYC,
   parameter int unsigned P_RATE_CYC = RATE_CYC,
   parameter int unsigned P_TIMEOUT_CYC = TIMEOUT_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic [10:0] i_local_sample,
   input wire logic [10:0] i_remote_sample,
   input wire logic i_remote_fault,
   output logic o_sda_out,
   output logic o_sda_oe,
   output logic o_adc_active,
   output logic o_adc_remote
);
   logic rst_meta;
   logic rst_n;
   logic scl_meta;
   logic scl_s;
   logic scl_q;
   logic sda_meta;
   logic sda_s;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic timeout;
   logic [CNT_W-1:0] low_cnt;
   dtsr_bus_e state;
   logic [3:0] bitcnt;
   logic [7:0] shreg;
   logic is_read;
   logic byte_full;
   logic cmd_take;
   logic data_take;
   logic addr_hit;
   logic oneshot_cmd;
   logic cfg_write;
   logic [7:0] pointer;
   logic [7:0] config_reg;
   logic oneshot;
   logic [7:0] rd_byte;
   logic busy;
   logic [7:0] local_whole;
   logic [7:0] local_frac;
   logic [7:0] remote_whole;
   logic [7:0] remote_frac;

   // reset asserts at once and is removed two clocks later
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // scl: two-flop synchroniser plus an edge stage; idle bus level is high
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_meta <= 1'b1;
         scl_s <= 1'b1;
         scl_q <= 1'b1;
      end else begin
         scl_meta <= i_scl;
         scl_s <= scl_meta;
         scl_q <= scl_s;
      end
   end

   // sda: same depth as scl so start and stop line up with the clock
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_meta <= 1'b1;
         sda_s <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         sda_meta <= i_sda;
         sda_s <= sda_meta;
         sda_q <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign start_det = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_det = scl_s & scl_q & ~sda_q & sda_s;
   assign byte_full = (bitcnt == BYTE_BITS);
   assign timeout = (low_cnt == CNT_W'(P_TIMEOUT_CYC));
   assign cmd_take = scl_fall && state == BUS_CMD && byte_full;
   assign data_take = scl_fall && state == BUS_WDATA && byte_full;
   // decoded bus events
   assign addr_hit = (shreg[7:1] == DEV_ADDR);
   assign oneshot_cmd = cmd_take && (shreg == ONESHOT_IDX);
   assign cfg_write = data_take && (pointer == CONFIG_IDX);

   // clock-low watchdog, saturates at the limit
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt <= '0;
      end else if (scl_s) begin
         low_cnt <= '0;
      end else if (!timeout) begin
         low_cnt <= low_cnt + CNT_W'(1);
      end
   end

   // read mux; a read byte snapshots it whole, so an update cannot tear it
   always_comb begin
      case (pointer)
         LOCAL_WHOLE_IDX: rd_byte = local_whole;
         REMOTE_WHOLE_IDX: rd_byte = remote_whole;
         STATUS_IDX: rd_byte = 8'(busy) << STATUS_BUSY_BIT;
         CONFIG_IDX: rd_byte = config_reg;
         REMOTE_FRAC_IDX: rd_byte = remote_frac;
         LOCAL_FRAC_IDX: rd_byte = local_frac;
         default: rd_byte = 8'h00;
      endcase
   end

   // direction bit of the address just acknowledged
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         is_read <= 1'b0;
      end else if (scl_fall && state == BUS_ADDR && byte_full && addr_hit) begin
         is_read <= shreg[0];
      end
   end

   // protocol engine: samples on rising scl, drives on falling scl
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= BUS_IDLE;
         bitcnt <= '0;
         shreg <= '0;
         o_sda_oe <= 1'b0;
      end else if (start_det) begin
         state <= BUS_ADDR;
         bitcnt <= '0;
         o_sda_oe <= 1'b0;
      end else if (stop_det || timeout) begin
         state <= BUS_IDLE;
         bitcnt <= '0;
         o_sda_oe <= 1'b0;
      end else if (scl_rise) begin
         case (state)
            BUS_ADDR, BUS_CMD, BUS_WDATA: begin
               shreg <= {shreg[6:0], sda_s};
               bitcnt <= bitcnt + 4'h1;
            end
            BUS_RDATA: begin
               bitcnt <= bitcnt + 4'h1;
            end
            BUS_RDATA_ACK: begin
               state <= BUS_IGNORE;
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (state)
            BUS_ADDR: begin
               if (byte_full) begin
                  if (addr_hit) begin
                     o_sda_oe <= 1'b1;
                     state <= BUS_ADDR_ACK;
                  end else begin
                     state <= BUS_IGNORE;
                  end
               end
            end
            BUS_ADDR_ACK: begin
               bitcnt <= '0;
               if (is_read) begin
                  shreg <= rd_byte;
                  o_sda_oe <= ~rd_byte[7];
                  state <= BUS_RDATA;
               end else begin
                  o_sda_oe <= 1'b0;
                  state <= BUS_CMD;
               end
            end
            BUS_CMD: begin
               if (byte_full) begin
                  o_sda_oe <= 1'b1;
                  state <= BUS_CMD_ACK;
               end
            end
            BUS_CMD_ACK: begin
               o_sda_oe <= 1'b0;
               bitcnt <= '0;
               state <= BUS_WDATA;
            end
            BUS_WDATA: begin
               if (byte_full) begin
                  o_sda_oe <= 1'b1;
                  state <= BUS_WDATA_ACK;
               end
            end
            BUS_WDATA_ACK: begin
               o_sda_oe <= 1'b0;
               state <= BUS_IGNORE;
            end
            BUS_RDATA: begin
               if (byte_full) begin
                  o_sda_oe <= 1'b0;
                  state <= BUS_RDATA_ACK;
               end else begin
                  shreg <= {shreg[6:0], 1'b0};
                  o_sda_oe <= ~shreg[6];
               end
            end
            default: begin
               o_sda_oe <= 1'b0;
            end
         endcase
      end
   end

   // open-drain pin: value always low, the enable does the driving
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_sda_out <= 1'b0;
      end else begin
         o_sda_out <= 1'b0;
      end
   end

   // pointer persists across transactions for receive-byte
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         pointer <= POINTER_RESET;
      end else if (cmd_take) begin
         pointer <= shreg;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         config_reg <= CONFIG_RESET;
      end else if (cfg_write) begin
         config_reg <= shreg;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         oneshot <= 1'b0;
      end else begin
         oneshot <= oneshot_cmd;
      end
   end

   // converter keeps registers in standby; slave logic never gated by it
   dtsr_conv_seq #(
      .P_PHASE_CYC(P_PHASE_CYC),
      .P_RATE_CYC(P_RATE_CYC)
   ) u_conv (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_standby(config_reg[CFG_STANDBY_BIT]),
      .i_oneshot(oneshot),
      .i_local_sample(i_local_sample),
      .i_remote_sample(i_remote_sample),
      .i_remote_fault(i_remote_fault),
      .o_busy(busy),
      .o_adc_active(o_adc_active),
      .o_adc_remote(o_adc_remote),
      .o_local_whole(local_whole),
      .o_local_frac(local_frac),
      .o_remote_whole(remote_whole),
      .o_remote_frac(remote_frac)
   );
endmodule : dtsr_top
`default_nettype wire

// ===== pkg/dtsr_pkg.sv
`default_nettype none
package dtsr_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   // wide enough for the full idle gap between automatic conversions
   localparam int unsigned CNT_W = 26;
   // conversion sequence length, split evenly over the two channels
   localparam int unsigned CONV_TIME_MS = 125;
   localparam int unsigned PHASE_CYC = CONV_TIME_MS * (CLK_HZ / 1000) / 2;
   // idle gap between automatic conversions
   localparam int unsigned RATE_IDLE_MS = 875;
   localparam int unsigned RATE_CYC = RATE_IDLE_MS * (CLK_HZ / 1000);
   // clock-low bus timeout, inside the 25..55 ms window
   localparam int unsigned TIMEOUT_MS = 35;
   localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);

   // slave address, value arbitrary
   localparam logic [6:0] DEV_ADDR = 7'h2A;

   localparam logic [7:0] LOCAL_WHOLE_IDX = 8'h00;
   localparam logic [7:0] REMOTE_WHOLE_IDX = 8'h01;
   localparam logic [7:0] STATUS_IDX = 8'h02;
   localparam logic [7:0] CONFIG_IDX = 8'h03;
   localparam logic [7:0] ONESHOT_IDX = 8'h0F;
   localparam logic [7:0] REMOTE_FRAC_IDX = 8'h10;
   localparam logic [7:0] LOCAL_FRAC_IDX = 8'h11;

   localparam int unsigned CFG_STANDBY_BIT = 6;
   localparam int unsigned STATUS_BUSY_BIT = 7;
   localparam logic [7:0] POINTER_RESET = 8'h00;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] FAULT_WHOLE = 8'hFF;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   typedef enum logic [3:0] {
      BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_CMD, BUS_CMD_ACK,
      BUS_WDATA, BUS_WDATA_ACK, BUS_RDATA, BUS_RDATA_ACK, BUS_IGNORE
   } dtsr_bus_e;

   typedef enum logic [1:0] {
      CONV_IDLE, CONV_LOCAL, CONV_REMOTE
   } dtsr_conv_e;
endpackage : dtsr_pkg
`default_nettype wire

// ===== tb/dtsr_host.sv
`timescale 1ns/1ps
`default_nettype none
module dtsr_host (
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   // extra low cycles per bit, for a slow host
   int stretch = 0;
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic half();
      repeat (4) @(posedge i_clk);
   endtask : half
   task automatic start();
      o_sda_low <= 1'b0;
      half();
      o_scl <= 1'b1;
      half();
      o_sda_low <= 1'b1;
      half();
      o_scl <= 1'b0;
   endtask : start
   task automatic stop();
      o_sda_low <= 1'b1;
      half();
      o_scl <= 1'b1;
      half();
      o_sda_low <= 1'b0;
      half();
   endtask : stop
   task automatic bit_x(input logic b, output logic r);
      repeat (2 + stretch) @(posedge i_clk);
      o_sda_low <= !b;
      repeat (2) @(posedge i_clk);
      o_scl <= 1'b1;
      half();
      r = i_sda;
      o_scl <= 1'b0;
   endtask : bit_x
   // msb first, then the ninth (acknowledge) bit
   task automatic byte_x(input logic [7:0] w, input logic last, output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_x(w[i], r[i]);
      end
      bit_x(last, ack);
   endtask : byte_x
endmodule : dtsr_host
`default_nettype wire

// ===== tb/dtsr_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dtsr_properties #(
   parameter int unsigned P_PHASE_CYC = 20,
   parameter int unsigned P_TIMEOUT_CYC = 400
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic o_sda_out,
   input wire logic o_sda_oe,
   input wire logic o_adc_active,
   input wire logic o_adc_remote
);
   localparam int PH_LO = P_PHASE_CYC - 2;
   localparam int PH_HI = P_PHASE_CYC + 2;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic [23:0] low_cnt;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         low_cnt <= '0;
      end else if (i_scl) begin
         low_cnt <= '0;
      end else if (low_cnt != 24'hff_ffff) begin
         low_cnt <= low_cnt + 24'h00_0001;
      end
   end
   sequence remote_start;
      $rose(o_adc_remote);
   endsequence
   sequence remote_end;
      ##[PH_LO:PH_HI] $fell(o_adc_active);
   endsequence
   sda_out_low_a: assert property (o_sda_out == 1'b0)
      else $error("sda output value not low");
   local_first_a: assert property ($rose(o_adc_active) |-> !o_adc_remote)
      else $error("conversion did not start on local channel");
   remote_inside_a: assert property (o_adc_remote |-> o_adc_active)
      else $error("remote phase outside a conversion");
   local_len_a: assert property (remote_start |-> $past(o_adc_active, PH_LO) && !$past(o_adc_remote, PH_LO))
      else $error("local phase too short");
   remote_len_a: assert property (remote_start |-> remote_end)
      else $error("remote phase length wrong");
   sda_hold_a: assert property ($rose(i_scl) |=> $stable(o_sda_oe) [*3])
      else $error("sda changed while clock high");
   bit_stand_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*3])
      else $error("driven bit too short");
   timeout_rel_a: assert property (low_cnt > P_TIMEOUT_CYC + 8 |-> !o_sda_oe)
      else $error("sda held after bus timeout");
endmodule : dtsr_properties
bind dtsr_top dtsr_properties #(.P_PHASE_CYC(P_PHASE_CYC), .P_TIMEOUT_CYC(P_TIMEOUT_CYC)) u_props (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .o_sda_out(o_sda_out),
   .o_sda_oe(o_sda_oe), .o_adc_active(o_adc_active), .o_adc_remote(o_adc_remote));
`default_nettype wire

// ===== tb/dtsr_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dtsr_tb_top;
   import dtsr_pkg::*;
   localparam int PH = 300;
   logic i_clk, i_rst_n = 1'b0, fault = 1'b0, host_low, scl, oe, sda_out, act, remo, got_v = 1'b0;
   logic [10:0] loc = 11'h000, rem = 11'h000;
   logic [7:0] got, ol;
   logic [7:0] exp_q[$];
   int mismatches = 0, checked = 0;
   int seed = 32'h0000_027a;
   wire sda = !(host_low || oe);
   dtsr_top #(.P_PHASE_CYC(PH), .P_RATE_CYC(200), .P_TIMEOUT_CYC(400)) u_dut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda), .i_local_sample(loc),
      .i_remote_sample(rem), .i_remote_fault(fault), .o_sda_out(sda_out), .o_sda_oe(oe),
      .o_adc_active(act), .o_adc_remote(remo));
   dtsr_host u_host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      checked++;
      if (seen !== want) begin
         mismatches++;
         $display("ERROR %0t: saw %h want %h", $time, seen, want);
      end
   endtask : chk
   always @(posedge i_clk) begin
      if (got_v) begin
         chk(got, exp_q.pop_front());
      end
   end
   task automatic note(input logic [7:0] seen, input logic [7:0] want);
      exp_q.push_back(want);
      got <= seen;
      got_v <= 1'b1;
      @(posedge i_clk);
      got_v <= 1'b0;
   endtask : note
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic wait_on(input logic want);
      int n = 0;
      while (act !== want && n < 5000) begin
         @(posedge i_clk);
         n++;
      end
      if (n >= 5000) begin
         mismatches++;
         $display("ERROR %0t: wait ran out", $time);
         tally_and_finish();
      end
   endtask : wait_on
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic has_d);
      logic [7:0] r;
      logic a;
      u_host.start();
      u_host.byte_x({DEV_ADDR, 1'b0}, 1'b1, r, a);
      u_host.byte_x(idx, 1'b1, r, a);
      note({7'h00, a}, 8'h00);
      if (has_d) begin
         u_host.byte_x(d, 1'b1, r, a);
      end
      u_host.stop();
   endtask : wr
   task automatic rd(input logic [7:0] idx, input logic use_cmd, input logic [7:0] want);
      logic [7:0] r;
      logic a;
      if (use_cmd) begin
         u_host.start();
         u_host.byte_x({DEV_ADDR, 1'b0}, 1'b1, r, a);
         u_host.byte_x(idx, 1'b1, r, a);
      end
      u_host.start();
      u_host.byte_x({DEV_ADDR, 1'b1}, 1'b1, r, a);
      u_host.byte_x(8'hff, 1'b1, r, a);
      note(r, want);
      u_host.stop();
   endtask : rd
   task automatic quiet(input int cyc);
      logic hi = 1'b0;
      repeat (cyc) begin
         @(posedge i_clk);
         hi = hi | act;
      end
      note({7'h00, hi}, 8'h00);
   endtask : quiet
   initial begin
      logic [7:0] r;
      logic a;
      loc <= 11'($random(seed));
      rem <= 11'($random(seed));
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      wait_on(1'b1);
      wait_on(1'b0);
      rd(LOCAL_WHOLE_IDX, 1'b1, loc[10:3]);
      rd(REMOTE_WHOLE_IDX, 1'b1, rem[10:3]);
      rd(REMOTE_FRAC_IDX, 1'b1, {rem[2:0], 5'h00});
      rd(LOCAL_FRAC_IDX, 1'b1, {loc[2:0], 5'h00});
      rd(8'h00, 1'b0, {loc[2:0], 5'h00});
      rd(8'h05, 1'b1, 8'h00);
      $display("free run readout done");
      ol = loc[10:3];
      wait_on(1'b0);
      wait_on(1'b1);
      loc <= 11'($random(seed));
      rd(LOCAL_WHOLE_IDX, 1'b1, ol);
      wait_on(1'b0);
      wait_on(1'b1);
      rd(STATUS_IDX, 1'b1, 8'h80);
      wait_on(1'b0);
      rd(8'h00, 1'b0, 8'h00);
      rd(LOCAL_WHOLE_IDX, 1'b1, loc[10:3]);
      $display("busy and hold done");
      fault <= 1'b1;
      wait_on(1'b0);
      wait_on(1'b1);
      wait_on(1'b0);
      rd(REMOTE_WHOLE_IDX, 1'b1, 8'hff);
      rd(REMOTE_FRAC_IDX, 1'b1, {rem[2:0], 5'h00});
      fault <= 1'b0;
      u_host.start();
      u_host.byte_x({DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, r, a);
      note({7'h00, a}, 8'h01);
      u_host.stop();
      $display("fault and address done");
      ol = loc[10:3];
      wait_on(1'b0);
      wait_on(1'b1);
      loc <= 11'($random(seed));
      wr(CONFIG_IDX, 8'h40, 1'b1);
      repeat (20) @(posedge i_clk);
      quiet(1500);
      rd(LOCAL_WHOLE_IDX, 1'b1, ol);
      rd(CONFIG_IDX, 1'b1, 8'h40);
      $display("standby done");
      wr(ONESHOT_IDX, 8'h00, 1'b0);
      wait_on(1'b1);
      wr(ONESHOT_IDX, 8'h00, 1'b0);
      wait_on(1'b0);
      quiet(1000);
      rd(LOCAL_WHOLE_IDX, 1'b1, loc[10:3]);
      rd(CONFIG_IDX, 1'b1, 8'h40);
      $display("one-shot done");
      u_host.start();
      u_host.byte_x({DEV_ADDR, 1'b1}, 1'b1, r, a);
      repeat (500) @(posedge i_clk);
      note({7'h00, sda}, 8'h01);
      u_host.stop();
      u_host.stretch = 3;
      rd(CONFIG_IDX, 1'b1, 8'h40);
      $display("timeout done");
      tally_and_finish();
   end
endmodule : dtsr_tb_top
`default_nettype wire
